//--- logic/pscr_pkg.sv
// Constants and types shared by both ends of the PLL scan-chain link.
// Assumes one 100 MHz ref_clk feeding both ends.
package pscr_pkg;

   // ----------------------------------------
   // Chain geometry
   // ----------------------------------------
   localparam int CHAIN_LEN = 144;
   localparam int SECT_LEN = 18;
   localparam int N_CNT = 7;
   localparam int CNT_W = 8;
   // Field positions inside one counter section
   localparam int F_LOW = 0;
   localparam int F_HIGH = 8;
   localparam int F_BYPASS = 16;
   localparam int F_ODD = 17;
   // Trailing analogue codes
   localparam int CP_POS = 126;
   localparam int LF_POS = 135;
   localparam int CODE_W = 9;
   // Sections 5 and 6 (feedback, prescale) plus the analogue codes
   localparam int LOOP_POS = 90;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int REF_CLK_MHZ = 100;
   localparam int SHIFT_CLK_MAX_MHZ = 100;
   // Half period of the shift clock in ref_clk cycles, rounded up
   localparam int SHIFT_HALF_CYC =
      (REF_CLK_MHZ + 2 * SHIFT_CLK_MAX_MHZ - 1) / (2 * SHIFT_CLK_MAX_MHZ);

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [CHAIN_LEN-1:0] CHAIN_RST = '0;

   typedef enum logic [2:0] {
      PSCR_IDLE, PSCR_ARM, PSCR_LEAD, PSCR_SHIFT,
      PSCR_UPD, PSCR_WAIT, PSCR_RST, PSCR_FIN
   } pscr_state_t;

endpackage

//--- logic/pscr_link_if.sv
// Link between the controlling logic and the PLL reconfiguration port.
// Assumes both ends share ref_clk; no pin here is two-way.
`timescale 1ns/1ps
`default_nettype none
interface pscr_link_if;
   logic chain_shift_clk;
   logic shift_enable;
   logic chain_serial_in;
   logic apply_settings_strobe;
   logic pll_async_reset;
   logic chain_serial_out;
   logic reconfig_done_flag;

   modport device (
      input chain_shift_clk,
      input shift_enable,
      input chain_serial_in,
      input apply_settings_strobe,
      input pll_async_reset,
      output chain_serial_out,
      output reconfig_done_flag
   );

   modport host (
      output chain_shift_clk,
      output shift_enable,
      output chain_serial_in,
      output apply_settings_strobe,
      output pll_async_reset,
      input chain_serial_out,
      input reconfig_done_flag
   );
endinterface
`default_nettype wire

//--- logic/pscr_divider.sv
// One PLL counter: high/low time divider with bypass and odd-duty option.
// Assumes tick_rise/tick_fall are alternating one-cycle VCO edge pulses.
`timescale 1ns/1ps
`default_nettype none
module pscr_divider (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Oscillator edges and loop reset
   input wire logic tick_rise,
   input wire logic tick_fall,
   input wire logic pll_reset,
   // New settings
   input wire logic load_req,
   input wire logic [pscr_pkg::CNT_W-1:0] cfg_high,
   input wire logic [pscr_pkg::CNT_W-1:0] cfg_low,
   input wire logic cfg_bypass,
   input wire logic cfg_odd,
   // Result
   output logic clk_out,
   output logic busy
);
   import pscr_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] high;
      logic [CNT_W-1:0] low;
      logic bypass;
      logic odd;
      logic [CNT_W:0] cnt;
      logic pending;
      logic out;
   } pscr_div_t;

   pscr_div_t st_r;
   pscr_div_t st_nxt;
   logic [CNT_W:0] last;
   logic [CNT_W:0] nc;

   always_comb begin
      st_nxt = st_r;
      last = ({1'b0, st_r.high} + {1'b0, st_r.low} == '0) ? '0 :
             {1'b0, st_r.high} + {1'b0, st_r.low} - 9'h001;
      nc = (st_r.cnt == last) ? '0 : st_r.cnt + 9'h001;
      if (load_req) begin
         st_nxt.pending = 1'b1;
      end
      if (pll_reset) begin
         st_nxt.cnt = '0;
         st_nxt.out = 1'b0;
      end else if (tick_rise) begin
         if (st_r.pending && (st_r.bypass || st_r.cnt == last)) begin
            st_nxt.high = cfg_high;
            st_nxt.low = cfg_low;
            st_nxt.bypass = cfg_bypass;
            st_nxt.odd = cfg_odd;
            st_nxt.pending = 1'b0;
            st_nxt.cnt = '0;
            st_nxt.out = cfg_bypass || (cfg_high != '0);
         end else begin
            st_nxt.cnt = nc;
            st_nxt.out = st_r.bypass || (nc < {1'b0, st_r.high});
         end
      end else if (tick_fall) begin
         if (st_r.bypass) begin
            st_nxt.out = 1'b0;
         end else if (st_r.odd && st_r.high != '0 &&
                      st_r.cnt == {1'b0, st_r.high} - 9'h001) begin
            st_nxt.out = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clk_out = st_r.out;
   assign busy = st_r.pending;
endmodule // pscr_divider
`default_nettype wire

//--- logic/pscr_device.sv
// PLL reconfiguration end: 144-bit scan chain, update and counters.
// Assumes link pins come from another party and are synchronised here.
//
// What this block and its controller do
// - Chain is exactly 144 bits long.
// - Controller keeps shift clock at most 100 MHz.
// - Controller raises enable one shift cycle early.
// - First bit taken on second enabled rise.
// - Controller drops enable after 144 bits.
// - Chain moves only while enable is high.
// - Strobe held one cycle copies chain into settings.
// - Each counter updates on its own clock.
// - Done flag high during update, falls after.
// - Controller resets PLL after loop setting change.
// - Sequence may repeat any number of times.
// - Chain contents shift out serially.
// - Chain never touches phase settings.
// - Counters have 8-bit high and low times.
// - Bypass bit gives divide by one.
// - Odd bit clear: falls on oscillator rise.
// - Odd bit set: falls on oscillator fall.
// - Seven 18-bit sections then 9+9 code bits.
// - First bit: last post-scale low LSB.
`timescale 1ns/1ps
`default_nettype none
module pscr_device #(
   parameter int CHAIN_BITS = pscr_pkg::CHAIN_LEN
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Link to the controlling logic
   pscr_link_if.device link,
   // Divided outputs: 0..4 post-scale, last first; 5 feedback, 6 prescale
   output logic [pscr_pkg::N_CNT-1:0] div_clk_out,
   // Applied analogue codes
   output logic [pscr_pkg::CODE_W-1:0] charge_pump_current,
   output logic [pscr_pkg::CODE_W-1:0] loop_filter_code
);
   import pscr_pkg::*;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // section layout
   if (CHAIN_BITS != N_CNT * SECT_LEN + 2 * CODE_W) begin : g_len_chk
      $error("chain length does not match section layout");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Sync bit order: 0 clock, 1 enable, 2 data, 3 strobe, 4 loop reset
   localparam int NSYNC = 5;

   typedef struct packed {
      logic [NSYNC-1:0] sync1;
      logic [NSYNC-1:0] sync2;
      logic clk_prev;
      logic armed;
      logic strobe_taken;
      logic [CHAIN_BITS-1:0] chain;
      logic [CHAIN_BITS-1:0] image;
      logic load_req;
      logic done;
      logic vco_phase;
      logic [N_CNT-1:0] div_out;
   } pscr_dev_t;

   pscr_dev_t st_r;
   pscr_dev_t st_nxt;

   logic shift_rise;
   logic en_s;
   logic data_s;
   logic strobe_s;
   logic loop_rst_s;
   logic tick_rise;
   logic tick_fall;
   logic [N_CNT-1:0] div_clk;
   logic [N_CNT-1:0] div_busy;

   // ----------------------------------------
   // Synchronised link view
   // ----------------------------------------
   // Only the second stage feeds logic; the first is metastability room
   assign shift_rise = st_r.sync2[0] && !st_r.clk_prev;
   assign en_s = st_r.sync2[1];
   assign data_s = st_r.sync2[2];
   assign strobe_s = st_r.sync2[3];
   assign loop_rst_s = st_r.sync2[4];

   // Oscillator model: one VCO period is two ref_clk cycles
   assign tick_rise = !st_r.vco_phase;
   assign tick_fall = st_r.vco_phase;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = {link.pll_async_reset, link.apply_settings_strobe,
                      link.chain_serial_in, link.shift_enable,
                      link.chain_shift_clk};
      st_nxt.sync2 = st_r.sync1;
      st_nxt.clk_prev = st_r.sync2[0];
      st_nxt.vco_phase = !st_r.vco_phase;
      st_nxt.load_req = 1'b0;
      st_nxt.div_out = div_clk;

      if (!en_s) begin
         st_nxt.armed = 1'b0;
      end else if (shift_rise) begin
         if (st_r.armed) begin
            // first bit walks down to bit 0
            st_nxt.chain = {data_s, st_r.chain[CHAIN_BITS-1:1]};
         end else begin
            st_nxt.armed = 1'b1;
         end
      end

      if (!strobe_s) begin
         st_nxt.strobe_taken = 1'b0;
      end else if (shift_rise && !en_s && !st_r.strobe_taken && !st_r.done) begin
         st_nxt.image = st_r.chain;
         st_nxt.load_req = 1'b1;
         st_nxt.strobe_taken = 1'b1;
      end

      // high until every counter took its value
      st_nxt.done = st_nxt.load_req || (|div_busy) || st_r.load_req;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
         st_r.chain <= CHAIN_RST;
         st_r.image <= CHAIN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   // no phase fields decoded from the image
   for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
      pscr_divider u_div (
         .ref_clk(ref_clk),
         .reset(reset),
         .tick_rise(tick_rise),
         .tick_fall(tick_fall),
         .pll_reset(loop_rst_s),
         .load_req(st_r.load_req),
         .cfg_high(st_r.image[i*SECT_LEN+F_HIGH +: CNT_W]),
         .cfg_low(st_r.image[i*SECT_LEN+F_LOW +: CNT_W]),
         .cfg_bypass(st_r.image[i*SECT_LEN+F_BYPASS]),
         .cfg_odd(st_r.image[i*SECT_LEN+F_ODD]),
         .clk_out(div_clk[i]),
         .busy(div_busy[i])
      );
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // serial view of the chain
   assign link.chain_serial_out = st_r.chain[0];
   assign link.reconfig_done_flag = st_r.done;
   assign div_clk_out = st_r.div_out;
   assign charge_pump_current = st_r.image[CP_POS +: CODE_W];
   assign loop_filter_code = st_r.image[LF_POS +: CODE_W];

endmodule // pscr_device
`default_nettype wire

//--- logic/pscr_host.sv
// Controlling end: shifts a 144-bit image, strobes the update, waits.
// Assumes the device end shares ref_clk; done flag is read unsynchronised.
`timescale 1ns/1ps
`default_nettype none
module pscr_host #(
   parameter int SHIFT_HALF = pscr_pkg::SHIFT_HALF_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Link to the device
   pscr_link_if.host link,
   // User side
   input wire logic start,
   input wire logic [pscr_pkg::CHAIN_LEN-1:0] image,
   output logic busy,
   output logic done_pulse,
   output logic [pscr_pkg::CHAIN_LEN-1:0] readback
);
   import pscr_pkg::*;

   if (SHIFT_HALF < SHIFT_HALF_CYC || SHIFT_HALF > 255) begin : g_half_chk
      $error("SHIFT_HALF out of range");
   end

   typedef struct packed {
      pscr_state_t state;
      logic [7:0] div;
      logic sclk;
      logic [7:0] bitcnt;
      logic [CHAIN_LEN-1:0] shreg;
      logic [CHAIN_LEN-1:0] cur;
      logic [CHAIN_LEN-1:0] last;
      logic [CHAIN_LEN-1:0] rb;
      logic [2:0] rb_pipe;
      logic have_last;
      logic saw_done;
      logic en;
      logic sdata;
      logic strobe;
      logic areset;
      logic busy;
      logic done;
   } pscr_host_t;

   pscr_host_t st_r;
   pscr_host_t st_nxt;
   logic fall;

   assign fall = (st_r.div == 8'(SHIFT_HALF - 1)) && st_r.sclk;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      // Shift clock runs free as a divided level
      if (st_r.div == 8'(SHIFT_HALF - 1)) begin
         st_nxt.div = '0;
         st_nxt.sclk = !st_r.sclk;
      end else begin
         st_nxt.div = st_r.div + 8'h01;
      end
      // readback of the old chain
      // Device acts three ref cycles after a pin edge, so sample that late
      st_nxt.rb_pipe = {st_r.rb_pipe[1:0],
         st_r.state == PSCR_SHIFT && !st_r.sclk && st_r.div == 8'(SHIFT_HALF - 1)};
      if (st_r.rb_pipe[2]) begin
         st_nxt.rb = {link.chain_serial_out, st_r.rb[CHAIN_LEN-1:1]};
      end
      // Outputs change on falling edges, device samples on rising ones
      unique case (st_r.state)
         PSCR_IDLE: begin
            if (start) begin
               st_nxt.shreg = image;
               st_nxt.cur = image;
               st_nxt.busy = 1'b1;
               st_nxt.state = PSCR_ARM;
            end
         end
         PSCR_ARM: begin
            if (fall) begin
               st_nxt.en = 1'b1;
               st_nxt.state = PSCR_LEAD;
            end
         end
         PSCR_LEAD: begin
            if (fall) begin
               st_nxt.sdata = st_r.shreg[0];
               st_nxt.shreg = st_r.shreg >> 1;
               st_nxt.bitcnt = '0;
               st_nxt.state = PSCR_SHIFT;
            end
         end
         PSCR_SHIFT: begin
            if (fall) begin
               if (st_r.bitcnt == 8'(CHAIN_LEN - 1)) begin
                  st_nxt.en = 1'b0;
                  st_nxt.state = PSCR_UPD;
               end else begin
                  st_nxt.sdata = st_r.shreg[0];
                  st_nxt.shreg = st_r.shreg >> 1;
                  st_nxt.bitcnt = st_r.bitcnt + 8'h01;
               end
            end
         end
         PSCR_UPD: begin
            if (fall) begin
               // strobe spans one full shift cycle
               st_nxt.strobe = 1'b1;
               st_nxt.saw_done = 1'b0;
               st_nxt.state = PSCR_WAIT;
            end
         end
         PSCR_WAIT: begin
            if (fall) begin
               st_nxt.strobe = 1'b0;
            end
            if (link.reconfig_done_flag) begin
               st_nxt.saw_done = 1'b1;
            end
            if (st_r.saw_done && !st_r.strobe && !link.reconfig_done_flag) begin
               if (!st_r.have_last ||
                   st_r.cur[CHAIN_LEN-1:LOOP_POS] != st_r.last[CHAIN_LEN-1:LOOP_POS]) begin
                  st_nxt.state = PSCR_RST;
               end else begin
                  st_nxt.state = PSCR_FIN;
               end
            end
         end
         PSCR_RST: begin
            if (fall) begin
               st_nxt.areset = !st_r.areset;
               if (st_r.areset) begin
                  st_nxt.state = PSCR_FIN;
               end
            end
         end
         PSCR_FIN: begin
            st_nxt.last = st_r.cur;
            st_nxt.have_last = 1'b1;
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.state = PSCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
         st_r.state <= PSCR_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.chain_shift_clk = st_r.sclk;
   assign link.shift_enable = st_r.en;
   assign link.chain_serial_in = st_r.sdata;
   assign link.apply_settings_strobe = st_r.strobe;
   assign link.pll_async_reset = st_r.areset;
   assign busy = st_r.busy;
   assign done_pulse = st_r.done;
   assign readback = st_r.rb;
endmodule // pscr_host
`default_nettype wire

//--- sim/pscr_link_properties.sv
// Checks on the link pins between the host end and the PLL end.
// Assumes one ref_clk and the host at one ref cycle per shift half.
`timescale 1ns/1ps
`default_nettype none
module pscr_link_properties (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Host to PLL end
   input wire logic chain_shift_clk,
   input wire logic shift_enable,
   input wire logic chain_serial_in,
   input wire logic apply_settings_strobe,
   input wire logic pll_async_reset,
   // PLL end to host
   input wire logic chain_serial_out,
   input wire logic reconfig_done_flag
);
   // Arming rise plus one rise per chain bit
   localparam int LOAD_RISES = 145;
   // Slowest counter reload with margin
   localparam int DONE_MAX = 1200;
   logic [8:0] rise_cnt_r;
   logic [10:0] done_len_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset || !shift_enable) begin
         rise_cnt_r <= 9'h000;
      end else if ($rose(chain_shift_clk)) begin
         rise_cnt_r <= rise_cnt_r + 9'h001;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset || !reconfig_done_flag) begin
         done_len_r <= 11'h000;
      end else begin
         done_len_r <= done_len_r + 11'h001;
      end
   end

   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   sequence s_update_req;
      $rose(apply_settings_strobe);
   endsequence
   sequence s_done_answer;
      1'b1 ##[1:16] reconfig_done_flag;
   endsequence
   sequence s_enable_quiet;
      (!shift_enable) [*6] ##1 !shift_enable;
   endsequence

   AST_DONE_ANSWER: assert property (s_update_req |-> s_done_answer)
      else $error("done flag missing after strobe");
   AST_DONE_BOUNDED: assert property (done_len_r <= DONE_MAX)
      else $error("done flag stuck high");
   AST_STROBE_ENABLE_LOW: assert property (apply_settings_strobe |-> !shift_enable)
      else $error("strobe while shifting");
   AST_STROBE_WIDTH: assert property (s_update_req |-> apply_settings_strobe [*2] ##1 !apply_settings_strobe)
      else $error("strobe not one shift period");
   AST_IDLE_DURING_DONE: assert property (reconfig_done_flag |-> !shift_enable && !pll_async_reset)
      else $error("link busy during update");
   AST_SERIAL_FROZEN: assert property (s_enable_quiet |-> $stable(chain_serial_out))
      else $error("chain moved with enable low");
   AST_ENABLE_COUNT: assert property ($fell(shift_enable) |-> rise_cnt_r == LOAD_RISES)
      else $error("wrong rise count in load");
   AST_DATA_ON_FALL: assert property ($changed(chain_serial_in) |-> $fell(chain_shift_clk))
      else $error("serial data moved off a fall");
   AST_ENABLE_LEAD: assert property ($rose(shift_enable) |=> $rose(chain_shift_clk) && $stable(chain_serial_in))
      else $error("data moved before first rise");
   AST_RESET_WIDTH: assert property ($rose(pll_async_reset) |-> pll_async_reset [*2] ##1 !pll_async_reset)
      else $error("loop reset not one shift period");
endmodule // pscr_link_properties
`default_nettype wire

//--- sim/pll_scan_chain_reconfig_bench.sv
// Bench: host and PLL end joined on link_a; a second PLL end on link_b
// is driven by hand, breaking the host's rules on purpose.
// Assumes design defaults: 144-bit chain, one ref cycle per shift half.
`timescale 1ns/1ps
`default_nettype none
module pll_scan_chain_reconfig_bench;
   import pscr_pkg::*;
   logic ref_clk, reset, start, busy, done_pulse;
   logic sclk_q = 1'b0, armed = 1'b0, ar_q = 1'b0, d2_q = 1'b0;
   logic [CHAIN_LEN-1:0] image, readback, cap, img_a, img_b;
   logic [N_CNT-1:0] div_clk_out;
   logic [CODE_W-1:0] cp, lf, cp2, lf2;
   int ncap = 0, rst_cnt = 0, d2_cnt = 0, failures = 0, checked = 0, cycles = 0;
   int hi, per, rst0, k;
   // Ref cycles; VCO runs at half ref rate
   int exp_hi[N_CNT] = '{4, 1, 3, 2, 0, 6, 6};
   int exp_per[N_CNT] = '{10, 2, 6, 4, 0, 8, 8};

   pscr_link_if link_a ();
   pscr_link_if link_b ();
   pscr_host pscr_host_inst (.ref_clk(ref_clk), .reset(reset), .link(link_a), .start(start),
      .image(image), .busy(busy), .done_pulse(done_pulse), .readback(readback));
   pscr_device pscr_device_inst (.ref_clk(ref_clk), .reset(reset), .link(link_a),
      .div_clk_out(div_clk_out), .charge_pump_current(cp), .loop_filter_code(lf));
   pscr_device pscr_device_inst2 (.ref_clk(ref_clk), .reset(reset), .link(link_b),
      .div_clk_out(), .charge_pump_current(cp2), .loop_filter_code(lf2));
   pscr_link_properties props (.ref_clk(ref_clk), .reset(reset),
      .chain_shift_clk(link_a.chain_shift_clk), .shift_enable(link_a.shift_enable),
      .chain_serial_in(link_a.chain_serial_in),
      .apply_settings_strobe(link_a.apply_settings_strobe),
      .pll_async_reset(link_a.pll_async_reset), .chain_serial_out(link_a.chain_serial_out),
      .reconfig_done_flag(link_a.reconfig_done_flag));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Wire monitor and timeout
   // ----------------------------------------
   always @(posedge ref_clk) begin
      sclk_q <= link_a.chain_shift_clk;
      ar_q <= link_a.pll_async_reset;
      d2_q <= link_b.reconfig_done_flag;
      cycles <= cycles + 1;
      if (link_a.pll_async_reset && !ar_q) rst_cnt <= rst_cnt + 1;
      if (link_b.reconfig_done_flag && !d2_q) d2_cnt <= d2_cnt + 1;
      if (!link_a.shift_enable) begin
         armed <= 1'b0;
      end else if (link_a.chain_shift_clk && !sclk_q) begin
         // First enabled rise only arms
         armed <= 1'b1;
         ncap <= armed ? ncap + 1 : 0;
         if (armed) cap <= {link_a.chain_serial_in, cap[CHAIN_LEN-1:1]};
      end
      if (cycles == 40000) begin
         failures++;
         $display("MISMATCH %0t timeout", $time);
         end_sim();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [SECT_LEN-1:0] sect(input int h, l, b, o);
      return {1'(o), 1'(b), 8'(h), 8'(l)};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic check(input logic [CHAIN_LEN-1:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic run_pass(input logic [CHAIN_LEN-1:0] img);
      int n;
      n = 0;
      rst0 = rst_cnt;
      @(posedge ref_clk);
      start <= 1'b1;
      image <= img;
      @(posedge ref_clk);
      start <= 1'b0;
      #1;
      check(144'(busy), 144'h1, "busy");
      while (done_pulse !== 1'b1 && n < 5000) begin
         tick(1);
         n++;
      end
      check(144'(n < 5000), 144'h1, "pass end");
      check(cap, img, "bit order");
      check(144'(ncap), 144'h90, "bit count");
      check(144'(cp), 144'(img[134:126]), "pump code");
      check(144'(lf), 144'(img[143:135]), "filter code");
   endtask

   // Cycles spent while counter output i equals v
   task automatic span(input int i, input logic v, output int c);
      c = 0;
      while (div_clk_out[i] === v && c < 300) begin
         tick(1);
         c++;
      end
   endtask

   task automatic measure(input int i);
      span(i, 1'b1, k);
      span(i, 1'b0, k);
      span(i, 1'b1, hi);
      span(i, 1'b0, per);
      per += hi;
   endtask

   // Hand driver: one shift period of 8 ref cycles, pins change at the fall
   task automatic drv2(input int n, input logic en, d, st);
      repeat (n) begin
         @(posedge ref_clk);
         link_b.chain_shift_clk <= 1'b0;
         link_b.shift_enable <= en;
         link_b.chain_serial_in <= d;
         link_b.apply_settings_strobe <= st;
         repeat (4) @(posedge ref_clk);
         link_b.chain_shift_clk <= 1'b1;
         repeat (3) @(posedge ref_clk);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      start = 1'b0;
      image = '0;
      link_b.chain_shift_clk = 1'b0;
      link_b.shift_enable = 1'b0;
      link_b.chain_serial_in = 1'b0;
      link_b.apply_settings_strobe = 1'b0;
      link_b.pll_async_reset = 1'b0;
      img_a = {9'h15A, 9'h0A5, sect(3, 1, 0, 0), sect(3, 1, 0, 0), sect(0, 0, 0, 0),
         sect(1, 1, 0, 0), sect(2, 1, 0, 1), sect(0, 0, 1, 0), sect(2, 3, 0, 0)};
      img_b = {img_a[CHAIN_LEN-1:SECT_LEN], sect(1, 4, 0, 0)};
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      run_pass(img_a);
      check(readback, '0, "first readback");
      check(144'(rst_cnt - rst0), 144'h1, "first loop reset");
      tick(8);
      for (int i = 0; i < N_CNT; i++) begin
         if (exp_per[i] == 0) begin
            check(144'(div_clk_out[i]), 144'h0, "idle counter");
         end else begin
            measure(i);
            check(144'(hi), 144'(exp_hi[i]), "high time");
            check(144'(per), 144'(exp_per[i]), "period");
         end
      end
      // Only post-scale bits change: no loop reset
      run_pass(img_b);
      check(readback, img_a, "second readback");
      check(144'(rst_cnt - rst0), 144'h0, "no loop reset");
      tick(8);
      measure(0);
      check(144'(hi), 144'h2, "new high time");
      check(144'(per), 144'hA, "new period");
      // Filter code changes: loop reset again
      run_pass({9'h0C3, img_b[LF_POS-1:0]});
      check(144'(rst_cnt - rst0), 144'h1, "third loop reset");
      // Second PLL end: data clocked with enable low must be ignored
      drv2(150, 1'b0, 1'b1, 1'b0);
      check(144'(link_b.chain_serial_out), 144'h0, "frozen chain");
      // Strobe while shifting is refused; arm then three bits
      drv2(4, 1'b1, 1'b1, 1'b1);
      check(144'(d2_cnt), 144'h0, "strobe refused");
      drv2(3, 1'b0, 1'b0, 1'b1);
      drv2(1, 1'b0, 1'b0, 1'b0);
      k = 0;
      while ((d2_cnt != 1 || link_b.reconfig_done_flag !== 1'b0) && k < 3000) begin
         tick(1);
         k++;
      end
      check(144'(k < 3000), 144'h1, "hand done fell");
      check(144'(d2_cnt), 144'h1, "hand update");
      check(144'(lf2), 144'h1C0, "hand filter code");
      check(144'(cp2), 144'h0, "hand pump code");
      end_sim();
   end
endmodule // pll_scan_chain_reconfig_bench
`default_nettype wire
